//--- src/jsl_pkg.sv
// package for jesd sync link init control
package jsl_pkg;
    localparam logic [7:0] JSL_ILAS_LEN = 8'h03; // ilas multiframes before data
    localparam logic [7:0] JSL_RST_CNT = 8'h00;
    localparam logic [7:0] JSL_SPI_BITS = 8'h10; // read command bits before data out

    typedef enum logic [1:0] {
        JSL_IDLE = 2'b00,
        JSL_CGS = 2'b01,
        JSL_ILAS = 2'b10,
        JSL_DATA = 2'b11
    } jsl_link_t;

    typedef enum logic [1:0] {
        JSL_SP_IDLE = 2'b00,
        JSL_SP_CMD = 2'b01,
        JSL_SP_READ = 2'b10,
        JSL_SP_WRITE = 2'b11
    } jsl_spi_t;

    typedef struct packed {
        logic sync_sel;
        logic mode_64b66b;
        logic link_en;
    } jsl_cfg_t;

    typedef struct packed {
        logic cgs;
        logic ilas;
        logic data;
        logic nco_sync;
    } jsl_lane_t;

    typedef struct packed {
        jsl_link_t link;
        logic sync_q;
        logic [7:0] ilas_cnt;
        jsl_lane_t lane;
        jsl_spi_t sp;
        logic sclk_q;
        logic [7:0] bit_cnt;
        logic [7:0] shift;
        logic sdo;
        logic sdo_oe;
        logic sdi_bit;
        logic sdi_valid;
    } jsl_state_t;
endpackage

//--- src/jsl_link_ctrl.sv
// jesd sync driven link start-up and serial port pin control
// Overview of operation
// - in 8b/10b with select 0, single-ended active-low sync starts the link.
// - selected sync going low starts code group synchronization on lanes.
// - rising sync after cgs starts the initial lane alignment sequence.
// - in 64b/66b sync never starts the link; it triggers nco sync.
// - select 1 takes sync from the differential timestamp pair.
// - chip select low selects the serial port; high means deselected.
// - serial data output is driven only during a read operation.
// - controller supplies serial clock; data shifts in and out on it.
`timescale 1ns/1ps
module jsl_link_ctrl import jsl_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire jsl_cfg_t cfg_i,
    input wire logic sync_single_ended_in_n_i,
    input wire logic timestamp_diff_pair_p_i,
    input wire logic timestamp_diff_pair_n_i,
    input wire logic ilas_mf_i,
    input wire logic serial_port_select_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic [7:0] rd_data_i,
    output jsl_lane_t lane_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic sdi_bit_o,
    output logic sdi_valid_o
);
    jsl_state_t st;
    jsl_state_t next_st;
    logic sync_n;
    logic se_sync_n;
    logic pair_sync_n;
    // sclk is sampled by clk, so it must stay well below a quarter of clk
    logic sync_rise;
    logic sync_fall;
    logic sclk_rise;
    logic sclk_fall;

    always_comb begin
        // pair counts low unless p is high and n is low
        se_sync_n = sync_single_ended_in_n_i;
        pair_sync_n = timestamp_diff_pair_p_i & ~timestamp_diff_pair_n_i;
        case (cfg_i.sync_sel)
            1'b0: begin
                sync_n = se_sync_n;
            end
            1'b1: begin
                sync_n = pair_sync_n;
            end
            default: begin
                sync_n = 1'b1;
            end
        endcase
        // sync_q resets high so a high sync after reset is no false rise; a low sync gives a fall
        sync_rise = sync_n & ~st.sync_q;
        sync_fall = ~sync_n & st.sync_q;
        sclk_rise = sclk_i & ~st.sclk_q;
        sclk_fall = ~sclk_i & st.sclk_q;

        next_st = st;
        next_st.sync_q = sync_n;
        next_st.sclk_q = sclk_i;
        next_st.sdi_valid = 1'b0;
        next_st.lane.nco_sync = 1'b0;

        // link start-up state machine
        if (!cfg_i.link_en) begin
            next_st.link = JSL_IDLE;
            next_st.ilas_cnt = JSL_RST_CNT;
        end else if (cfg_i.mode_64b66b) begin
            // sync is only an nco trigger here
            next_st.link = JSL_DATA;
            next_st.lane.nco_sync = sync_fall;
            next_st.ilas_cnt = JSL_RST_CNT;
        end else begin
            case (st.link)
                JSL_IDLE: begin
                    if (!sync_n) begin
                        next_st.link = JSL_CGS;
                    end
                end
                JSL_CGS: begin
                    // repeat cgs until the receiver lets sync go high
                    if (sync_rise) begin
                        next_st.link = JSL_ILAS;
                        next_st.ilas_cnt = JSL_RST_CNT;
                    end
                end
                JSL_ILAS: begin
                    // count multiframes; leave after the last one
                    if (!sync_n) begin
                        next_st.link = JSL_CGS;
                        next_st.ilas_cnt = JSL_RST_CNT;
                    end else if (ilas_mf_i) begin
                        if (st.ilas_cnt == JSL_ILAS_LEN - 8'h01) begin
                            next_st.link = JSL_DATA;
                        end
                        next_st.ilas_cnt = st.ilas_cnt + 8'h01;
                    end
                end
                JSL_DATA: begin
                    if (!sync_n) begin
                        next_st.link = JSL_CGS;
                    end
                end
                default: begin
                    next_st.link = JSL_IDLE;
                end
            endcase
        end

        // lane flags follow the next state so they change with it
        case (next_st.link)
            JSL_IDLE: begin
                next_st.lane.cgs = 1'b0;
                next_st.lane.ilas = 1'b0;
                next_st.lane.data = 1'b0;
            end
            JSL_CGS: begin
                next_st.lane.cgs = 1'b1;
                next_st.lane.ilas = 1'b0;
                next_st.lane.data = 1'b0;
            end
            JSL_ILAS: begin
                next_st.lane.cgs = 1'b0;
                next_st.lane.ilas = 1'b1;
                next_st.lane.data = 1'b0;
            end
            JSL_DATA: begin
                next_st.lane.cgs = 1'b0;
                next_st.lane.ilas = 1'b0;
                next_st.lane.data = 1'b1;
            end
            default: begin
                next_st.lane.cgs = 1'b0;
                next_st.lane.ilas = 1'b0;
                next_st.lane.data = 1'b0;
            end
        endcase

        // serial port: 16 command bits, msb first; msb 1 means read
        if (serial_port_select_n_i) begin
            next_st.sp = JSL_SP_IDLE;
            next_st.sdo_oe = 1'b0;
            next_st.sdo = 1'b0;
            next_st.bit_cnt = JSL_RST_CNT;
            next_st.shift = 8'h00;
        end else begin
            case (st.sp)
                JSL_SP_IDLE: begin
                    // one clk of setup between select and the first sclk edge
                    next_st.sp = JSL_SP_CMD;
                    next_st.bit_cnt = JSL_RST_CNT;
                end
                JSL_SP_CMD: begin
                    if (sclk_rise) begin
                        next_st.sdi_bit = sdi_i;
                        next_st.sdi_valid = 1'b1;
                        if (st.bit_cnt == JSL_RST_CNT) begin
                            next_st.shift[0] = sdi_i;
                        end
                        next_st.bit_cnt = st.bit_cnt + 8'h01;
                        // last command bit: latch read data for the data phase
                        if (st.bit_cnt == JSL_SPI_BITS - 8'h01) begin
                            next_st.sp = st.shift[0] ? JSL_SP_READ : JSL_SP_WRITE;
                            next_st.shift = rd_data_i;
                        end
                    end
                end
                JSL_SP_READ: begin
                    if (sclk_fall) begin
                        next_st.sdo_oe = 1'b1;
                        next_st.sdo = st.shift[7];
                        next_st.shift = {st.shift[6:0], 1'b0};
                    end
                    // data phase still samples sdi on each rise
                    if (sclk_rise) begin
                        next_st.sdi_bit = sdi_i;
                        next_st.sdi_valid = 1'b1;
                    end
                end
                JSL_SP_WRITE: begin
                    // write bits are handed out one by one
                    if (sclk_rise) begin
                        next_st.sdi_bit = sdi_i;
                        next_st.sdi_valid = 1'b1;
                    end
                end
                default: begin
                    next_st.sp = JSL_SP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.link <= JSL_IDLE;
            st.sync_q <= 1'b1;
            st.ilas_cnt <= JSL_RST_CNT;
            st.lane <= '0;
            st.sp <= JSL_SP_IDLE;
            st.sclk_q <= 1'b0;
            st.bit_cnt <= JSL_RST_CNT;
            st.shift <= 8'h00;
            st.sdo <= 1'b0;
            st.sdo_oe <= 1'b0;
            st.sdi_bit <= 1'b0;
            st.sdi_valid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign lane_o = st.lane;
    assign sdo_o = st.sdo;
    assign sdo_oe_o = st.sdo_oe;
    assign sdi_bit_o = st.sdi_bit;
    assign sdi_valid_o = st.sdi_valid;
endmodule

//--- tb/jsl_rx_model.sv
// receiver model: holds sync low until the lanes have sent cgs a while
`timescale 1ns/1ps
module jsl_rx_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cgs_i,
    input wire logic resync_i,
    output logic sync_n_o
);
    logic [2:0] cnt;
    always_ff @(posedge clk_i) begin
        if (!rstn_i || resync_i) begin
            cnt <= 3'h0;
            sync_n_o <= 1'b0;
        end else if (cgs_i) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) sync_n_o <= 1'b1;
        end
    end
endmodule

//--- tb/jsl_link_ctrl_sva.sv
// assertions on the link start-up and serial port pins
`timescale 1ns/1ps
module jsl_link_ctrl_sva import jsl_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire jsl_cfg_t cfg_i,
    input wire logic sync_single_ended_in_n_i,
    input wire logic timestamp_diff_pair_p_i,
    input wire logic timestamp_diff_pair_n_i,
    input wire logic ilas_mf_i,
    input wire logic serial_port_select_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic [7:0] rd_data_i,
    input wire jsl_lane_t lane_o,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic sdi_bit_o,
    input wire logic sdi_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic sel = cfg_i.sync_sel;
    wire logic se = sync_single_ended_in_n_i;
    wire logic cs = serial_port_select_n_i;
    wire logic sy = sel ? timestamp_diff_pair_p_i & ~timestamp_diff_pair_n_i : se;
    wire logic b8 = cfg_i.link_en & ~cfg_i.mode_64b66b;
    wire logic b6 = cfg_i.link_en & cfg_i.mode_64b66b;
    a_sel0_cgs_start: assert property (b8 && !sel && $fell(se) |-> ##[1:2] lane_o.cgs)
        else $error("no cgs after sync low");
    a_sel1_cgs_start: assert property (b8 && sel && $fell(sy) |-> ##[1:2] lane_o.cgs)
        else $error("no cgs after pair sync low");
    a_rise_ilas: assert property (b8 && lane_o.cgs && $rose(sy) |-> ##[1:2] lane_o.ilas)
        else $error("no ilas after sync rise");
    a_low_holds_cgs: assert property ((b8 && !sy) [*3] |-> lane_o.cgs && !lane_o.ilas)
        else $error("left cgs while sync low");
    a_b66_no_link: assert property (b6 [*2] |-> !lane_o.cgs && !lane_o.ilas)
        else $error("sync started link in 64b66b");
    a_b66_nco: assert property (b6 && $fell(sy) |-> ##[1:2] lane_o.nco_sync)
        else $error("no nco pulse");
    a_cs_high_quiet: assert property (cs [*3] |-> !sdo_oe_o && !sdi_valid_o)
        else $error("port active while deselected");
    a_sclk_bit: assert property (!cs && $rose(sclk_i) |-> ##[1:2] sdi_valid_o)
        else $error("no bit on sclk rise");
    c_ilas: cover property (lane_o.ilas);
    c_data: cover property ($rose(lane_o.data));
    c_read: cover property ($rose(sdo_oe_o));
endmodule
bind jsl_link_ctrl jsl_link_ctrl_sva u_sva (.*);

//--- tb/tb_top.sv
// self-checking bench for jesd sync link init control
`timescale 1ns/1ps
`define CHK(n, e, s) total_checks++; if ((e) !== (s)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, s); end
module tb_top import jsl_pkg::*; ;
    logic clk_i = 0, rstn_i = 0, mf_i = 0, cs_n = 1, sclk = 0, sdi = 0, resync = 0;
    logic sync_n, b, sdo, oe, sbit, sval;
    logic [7:0] rd = 8'h00, mf = 8'h00;
    jsl_cfg_t cfg = '0;
    jsl_lane_t lane;
    int err_total = 0, total_checks = 0, seed = 94;
    logic q[$];
    jsl_rx_model rx (.clk_i(clk_i), .rstn_i(rstn_i), .cgs_i(lane.cgs), .resync_i(resync),
        .sync_n_o(sync_n));
    jsl_link_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg), .ilas_mf_i(mf_i),
        .sync_single_ended_in_n_i(cfg.sync_sel | sync_n),
        .timestamp_diff_pair_p_i(~cfg.sync_sel | sync_n),
        .timestamp_diff_pair_n_i(cfg.sync_sel & ~sync_n), .serial_port_select_n_i(cs_n),
        .sclk_i(sclk), .sdi_i(sdi), .rd_data_i(rd), .lane_o(lane), .sdo_o(sdo),
        .sdo_oe_o(oe), .sdi_bit_o(sbit), .sdi_valid_o(sval));
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        mf_i <= lane.ilas & ~mf_i;
        if (lane.ilas & ~mf_i) mf <= mf + 8'h01;
    end
    always @(posedge clk_i) if (sval === 1'b1) begin
        if (q.size() > 0) b = q.pop_front();
        else b = 1'bx;
        `CHK("sdi bit", b, sbit)
    end
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task spi_read();
        logic [15:0] cmd;
        cmd = {1'b1, 15'($random(seed))};
        rd <= 8'($random(seed));
        cs_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 24; i++) begin
            sclk <= 1'b0;
            sdi <= (i < 16) ? cmd[15 - i] : 1'b0;
            repeat (4) @(posedge clk_i);
            if (i >= 16) begin `CHK("sdo", rd[23 - i], sdo) `CHK("oe", 1'b1, oe) end
            q.push_back((i < 16) ? cmd[15 - i] : 1'b0);
            sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        cs_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("oe idle", 1'b0, oe)
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            cfg <= '{sync_sel: s[0], mode_64b66b: 1'b0, link_en: 1'b1};
            resync <= 1'b1;
            @(posedge clk_i);
            resync <= 1'b0;
            repeat (3) @(posedge clk_i);
            #1 mf = 8'h00;
            `CHK("cgs", 1'b1, lane.cgs)
            `CHK("ilas", 1'b0, lane.ilas)
            repeat (60) if (lane.data !== 1'b1) @(posedge clk_i);
            #1 `CHK("data", 1'b1, lane.data)
            `CHK("ilas count", JSL_ILAS_LEN, mf)
            $display("done sync select %0d", s);
        end
        cfg <= '{sync_sel: 1'b0, mode_64b66b: 1'b1, link_en: 1'b1};
        resync <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 `CHK("nco pulse", 1'b1, lane.nco_sync)
        repeat (10) @(posedge clk_i);
        #1 `CHK("b66 cgs", 1'b0, lane.cgs)
        `CHK("b66 data", 1'b1, lane.data)
        $display("done 64b66b");
        repeat (2) spi_read();
        $display("done serial read");
        complete_run();
    end
endmodule
